// file: rtl/cgr_pkg.sv
// package for the channel processor general register file
// assumes one 10 MHz clock domain and synchronous active-low reset
package cgr_pkg;

  localparam int REG_COUNT = 8;
  localparam int DATA_WIDTH = 32;
  localparam int INDEX_WIDTH = 3;

  // register indices with implicit uses
  localparam logic [2:0] ACCUM_INDEX = 3'h0;
  localparam logic [2:0] SRC_PTR_INDEX = 3'h4;
  localparam logic [2:0] DST_PTR_INDEX = 3'h5;
  localparam logic [2:0] LOOP_PRIORITY_INDEX = 3'h6;
  localparam logic [2:0] STATUS_INDEX = 3'h7;

  // loop_priority_control fields
  localparam int LOOP_COUNT_LSB = 0;
  localparam int LOOP_COUNT_WIDTH = 12;
  localparam int SERVICE_TYPE_LSB = 14;
  localparam int REQ_PRIO_LSB = 16;
  localparam int CUR_PRIO_LSB = 24;
  localparam logic [31:0] LOOP_PRIORITY_RESET = 32'h0000_0000;

  // status_pointer_word fields
  localparam int ZERO_FLAG_BIT = 0;
  localparam int NEG_FLAG_BIT = 1;
  localparam int CARRY_FLAG_BIT = 2;
  localparam int OVF_FLAG_BIT = 3;
  localparam int LOOP_ZERO_FLAG_BIT = 4;
  localparam int CHANNEL_ENABLE_BIT = 6;
  localparam int SEGMENT_PTR_LSB = 8;
  localparam int FLAG_COUNT = 5;
  localparam int PARAMETER_RAM_OFFSET_WIDTH = 6;
  localparam int PARAMETER_RAM_ADDR_WIDTH = 14;
  localparam logic [31:0] STATUS_WRITE_MASK = 32'h0000_ffff;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] GENERAL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    CGR_IDLE_type_s = 2'b00,
    CGR_RUN_type_s = 2'b01,
    CGR_ERR_type_s = 2'b11
  } cgr_chan_state_type;

endpackage

// file: rtl/cgr_flag_if.sv
// interface carrying flag update traffic inside the register file
// assumes the register file core and the flag merge unit share clk
`timescale 1ns/10ps
interface cgr_flag_if;
  logic [4:0] flag_mask;
  logic [4:0] flag_value;
  logic [31:0] wr_value;
  logic [31:0] merged;
  modport core (output flag_mask, output flag_value, output wr_value,
    input merged);
  modport merge (input flag_mask, input flag_value, input wr_value,
    output merged);
endinterface

// file: rtl/cgr_flag_merge.sv
// merges explicit writes with implicit flag results for status word
// assumes a purely combinational use by the register file core
`timescale 1ns/10ps
module cgr_flag_merge
  import cgr_pkg::*;
(
  cgr_flag_if.merge fl
);
  import cgr_pkg::*;

  always_comb begin
    fl.merged = fl.wr_value & STATUS_WRITE_MASK;
    for (int i = 0; i < FLAG_COUNT; i++) begin
      if (fl.flag_mask[i]) begin
        fl.merged[i] = fl.flag_value[i];
      end
    end
  end
endmodule // cgr_flag_merge

// file: rtl/cgr_regfile.sv
// channel processor general register file, eight 32-bit registers
// assumes pipeline drives ports synchronous to clk; no system bus access
`timescale 1ns/10ps
module cgr_regfile
  import cgr_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // two read ports for the pipeline
  input wire logic [cgr_pkg::INDEX_WIDTH-1:0] rd_a_index,
  output logic [cgr_pkg::DATA_WIDTH-1:0] rd_a_data,
  input wire logic [cgr_pkg::INDEX_WIDTH-1:0] rd_b_index,
  output logic [cgr_pkg::DATA_WIDTH-1:0] rd_b_data,
  // explicit write port
  input wire logic wr_enable,
  input wire logic wr_to_accum,
  input wire logic [cgr_pkg::INDEX_WIDTH-1:0] wr_index,
  input wire logic [cgr_pkg::DATA_WIDTH-1:0] wr_data,
  // implicit flag update
  input wire logic [cgr_pkg::FLAG_COUNT-1:0] flag_update_mask,
  input wire logic [cgr_pkg::FLAG_COUNT-1:0] flag_update_value,
  // copy pointer updates
  input wire logic src_ptr_update,
  input wire logic [cgr_pkg::DATA_WIDTH-1:0] src_ptr_next_value,
  input wire logic dst_ptr_update,
  input wire logic [cgr_pkg::DATA_WIDTH-1:0] dst_ptr_next_value,
  input wire logic loop_count_update,
  input wire logic [cgr_pkg::LOOP_COUNT_WIDTH-1:0] loop_count_next_value,
  output logic [cgr_pkg::DATA_WIDTH-1:0] src_ptr,
  output logic [cgr_pkg::DATA_WIDTH-1:0] dst_ptr,
  output logic [cgr_pkg::LOOP_COUNT_WIDTH-1:0] outer_loop_count,
  // parameter_ram addressing
  input wire logic [cgr_pkg::PARAMETER_RAM_OFFSET_WIDTH-1:0] parameter_ram_offset,
  output logic [cgr_pkg::PARAMETER_RAM_ADDR_WIDTH-1:0] parameter_ram_word_address,
  // context restore port
  input wire logic ctx_restore,
  input wire logic [cgr_pkg::INDEX_WIDTH-1:0] ctx_index,
  input wire logic [cgr_pkg::DATA_WIDTH-1:0] ctx_data,
  input wire logic [cgr_pkg::INDEX_WIDTH-1:0] ctx_save_index,
  output logic [cgr_pkg::DATA_WIDTH-1:0] ctx_save_data,
  // exit posting and channel control
  input wire logic exit_post,
  output logic post_valid,
  output logic [1:0] service_type,
  output logic [7:0] request_priority_number,
  output logic [7:0] current_priority_number,
  input wire logic service_request,
  output logic channel_enable_bit,
  output logic error_exit
);
  import cgr_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [DATA_WIDTH-1:0] gr_reg [REG_COUNT];
  logic [DATA_WIDTH-1:0] low_reg [6];
  logic [DATA_WIDTH-1:0] loop_priority_reg;
  logic [DATA_WIDTH-1:0] status_reg;
  logic [DATA_WIDTH-1:0] status_next;
  logic [INDEX_WIDTH-1:0] wr_target;
  cgr_chan_state_type chan_state_reg;
  cgr_chan_state_type chan_state_next;

  cgr_flag_if fl ();

  cgr_flag_merge u_merge (
    .fl(fl)
  );

  function automatic logic [DATA_WIDTH-1:0] read_reg(
      input logic [INDEX_WIDTH-1:0] idx,
      input logic [DATA_WIDTH-1:0] value);
    if (idx == STATUS_INDEX) begin
      read_reg = value & STATUS_WRITE_MASK;
    end else begin
      read_reg = value;
    end
  endfunction

  // one write source aimed at one register
  function automatic logic aimed_at(
      input logic enable,
      input logic [INDEX_WIDTH-1:0] idx,
      input logic [INDEX_WIDTH-1:0] target);
    aimed_at = enable && idx == target;
  endfunction

  // accumulator instructions name no destination
  assign wr_target = wr_to_accum ? ACCUM_INDEX : wr_index;

  // ****************************************
  // status word merge
  // ****************************************
  always_comb begin
    fl.flag_mask = flag_update_mask;
    fl.flag_value = flag_update_value;
    if (aimed_at(ctx_restore, ctx_index, STATUS_INDEX)) begin
      fl.wr_value = ctx_data;
    end else if (aimed_at(wr_enable, wr_target, STATUS_INDEX)) begin
      fl.wr_value = wr_data;
    end else begin
      fl.wr_value = gr_reg[STATUS_INDEX];
    end
    status_next = fl.merged;
  end

  // ****************************************
  // general registers zero to five
  // ****************************************
  always_ff @(posedge clk) begin
    for (int i = 0; i < 6; i++) begin
      if (!reset_n) begin
        low_reg[i] <= GENERAL_RESET;
      end else if (aimed_at(ctx_restore, ctx_index, INDEX_WIDTH'(i))) begin
        low_reg[i] <= ctx_data;
      end else if (aimed_at(wr_enable, wr_target, INDEX_WIDTH'(i))) begin
        low_reg[i] <= wr_data;
      end else if (i == 4 && src_ptr_update) begin
        low_reg[i] <= src_ptr_next_value;
      end else if (i == 5 && dst_ptr_update) begin
        low_reg[i] <= dst_ptr_next_value;
      end
    end
  end

  // ****************************************
  // loop and priority control
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      loop_priority_reg <= LOOP_PRIORITY_RESET;
    end else if (aimed_at(ctx_restore, ctx_index, LOOP_PRIORITY_INDEX)) begin
      loop_priority_reg <= ctx_data;
    end else if (aimed_at(wr_enable, wr_target, LOOP_PRIORITY_INDEX)) begin
      loop_priority_reg <= wr_data;
    end else if (loop_count_update) begin
      loop_priority_reg[LOOP_COUNT_LSB +: LOOP_COUNT_WIDTH] <=
        loop_count_next_value;
    end
  end

  // ****************************************
  // status word
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // ****************************************
  // register view for reads and checks
  // ****************************************
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      gr_reg[i] = low_reg[i];
    end
    gr_reg[LOOP_PRIORITY_INDEX] = loop_priority_reg;
    gr_reg[STATUS_INDEX] = status_reg;
  end

  // ****************************************
  // channel state on service requests
  // ****************************************
  always_comb begin
    chan_state_next = chan_state_reg;
    case (chan_state_reg)
      CGR_IDLE_type_s: begin
        if (service_request) begin
          if (gr_reg[STATUS_INDEX][CHANNEL_ENABLE_BIT]) begin
            chan_state_next = CGR_RUN_type_s;
          end else begin
            chan_state_next = CGR_ERR_type_s;
          end
        end
      end
      CGR_RUN_type_s: begin
        if (exit_post) begin
          chan_state_next = CGR_IDLE_type_s;
        end
      end
      CGR_ERR_type_s: begin
        chan_state_next = CGR_IDLE_type_s;
      end
      default: begin
        chan_state_next = CGR_IDLE_type_s;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chan_state_reg <= CGR_IDLE_type_s;
    end else begin
      chan_state_reg <= chan_state_next;
    end
  end

  assign error_exit = (chan_state_reg == CGR_ERR_type_s);

  // ****************************************
  // exit posting to the interrupt control unit
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      post_valid <= 1'b0;
      service_type <= 2'h0;
      request_priority_number <= 8'h00;
      current_priority_number <= 8'h00;
    end else begin
      post_valid <= exit_post;
      if (exit_post) begin
        service_type <= {1'b0,
          gr_reg[LOOP_PRIORITY_INDEX][SERVICE_TYPE_LSB]};
        request_priority_number <=
          gr_reg[LOOP_PRIORITY_INDEX][REQ_PRIO_LSB +: 8];
        current_priority_number <=
          gr_reg[LOOP_PRIORITY_INDEX][CUR_PRIO_LSB +: 8];
      end
    end
  end

  // ****************************************
  // read side, pointers and addressing
  // ****************************************
  // no bus decode exists; reads only via instruction and context ports
  assign rd_a_data = read_reg(rd_a_index, gr_reg[rd_a_index]);
  assign rd_b_data = read_reg(rd_b_index, gr_reg[rd_b_index]);
  assign ctx_save_data = read_reg(ctx_save_index, gr_reg[ctx_save_index]);
  assign src_ptr = gr_reg[SRC_PTR_INDEX];
  assign dst_ptr = gr_reg[DST_PTR_INDEX];
  assign outer_loop_count =
    gr_reg[LOOP_PRIORITY_INDEX][LOOP_COUNT_LSB +: LOOP_COUNT_WIDTH];
  assign channel_enable_bit = gr_reg[STATUS_INDEX][CHANNEL_ENABLE_BIT];
  assign parameter_ram_word_address =
    {gr_reg[STATUS_INDEX][SEGMENT_PTR_LSB +: 8], parameter_ram_offset};

  // ****************************************
  // assertions
  // ****************************************
  sequence s_exit;
    exit_post;
  endsequence

  sequence s_status_write;
    wr_enable && wr_target == STATUS_INDEX && !ctx_restore;
  endsequence

  sequence s_run_request;
    chan_state_reg == CGR_RUN_type_s && service_request && !exit_post;
  endsequence

  AST_UPPER_ZERO: assert property (
    @(posedge clk) disable iff (!reset_n)
    gr_reg[STATUS_INDEX][31:16] == 16'h0000)
    else $error("status upper half not zero");

  AST_READ_UPPER: assert property (
    @(posedge clk) disable iff (!reset_n)
    rd_a_index == STATUS_INDEX |-> rd_a_data[31:16] == 16'h0000)
    else $error("status read upper half not zero");

  AST_ACCUM_WRITE: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_enable && wr_to_accum && !ctx_restore
    |=> gr_reg[ACCUM_INDEX] == $past(wr_data))
    else $error("accumulator not written");

  AST_FLAG_WINS: assert property (
    @(posedge clk) disable iff (!reset_n)
    wr_enable && wr_target == STATUS_INDEX && flag_update_mask[0]
    |=> gr_reg[STATUS_INDEX][0] == $past(flag_update_value[0]))
    else $error("implicit zero flag lost to explicit write");

  AST_FLAG_MASKED: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_status_write |=> (gr_reg[STATUS_INDEX][4:0] & $past(flag_update_mask))
      == ($past(flag_update_value) & $past(flag_update_mask)))
    else $error("masked flags not taken from implicit update");

  AST_RESERVED_KEEP: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_status_write |=> gr_reg[STATUS_INDEX][15:5] == $past(wr_data[15:5]))
    else $error("status storage bits not written");

  AST_FLAG_HOLD: assert property (
    @(posedge clk) disable iff (!reset_n)
    !wr_enable && !ctx_restore && flag_update_mask == 5'h00
    |=> $stable(gr_reg[STATUS_INDEX][4:0]))
    else $error("flags changed without update");

  AST_SRC_POINTER: assert property (
    @(posedge clk) disable iff (!reset_n)
    src_ptr_update && !aimed_at(ctx_restore, ctx_index, SRC_PTR_INDEX)
      && !aimed_at(wr_enable, wr_target, SRC_PTR_INDEX)
    |=> src_ptr == $past(src_ptr_next_value))
    else $error("source pointer not updated");

  AST_LOOP_COUNT: assert property (
    @(posedge clk) disable iff (!reset_n)
    loop_count_update
      && !aimed_at(ctx_restore, ctx_index, LOOP_PRIORITY_INDEX)
      && !aimed_at(wr_enable, wr_target, LOOP_PRIORITY_INDEX)
    |=> outer_loop_count == $past(loop_count_next_value))
    else $error("outer loop count not updated");

  AST_TYPE_TOP: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_exit |=> post_valid && service_type[1] == 1'b0)
    else $error("service type top bit not forced zero");

  AST_PRIO_POST: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_exit |=> request_priority_number == $past(gr_reg[6][23:16])
      && current_priority_number == $past(gr_reg[6][31:24]))
    else $error("posted priorities wrong");

  AST_DISABLED_ERR: assert property (
    @(posedge clk) disable iff (!reset_n)
    chan_state_reg == CGR_IDLE_type_s && service_request
      && !channel_enable_bit |=> error_exit ##1 !error_exit)
    else $error("disabled channel request did not error");

  AST_RUN_IGNORE: assert property (
    @(posedge clk) disable iff (!reset_n)
    s_run_request |=> !error_exit)
    else $error("request while running raised error exit");

  AST_SEG_ADDR: assert property (
    @(posedge clk) disable iff (!reset_n)
    parameter_ram_word_address[5:0] == parameter_ram_offset
      && parameter_ram_word_address[13:6] == gr_reg[STATUS_INDEX][15:8])
    else $error("parameter_ram address wrong");

  AST_R6_RESET: assert property (
    @(posedge clk)
    !reset_n |=> gr_reg[LOOP_PRIORITY_INDEX] == LOOP_PRIORITY_RESET)
    else $error("loop priority register not reset");

endmodule // cgr_regfile

// file: sim/cgr_pipe_model.sv
// pipeline and alu stand-in driving the register file write side
// assumes the bench calls its tasks; changes follow a rising clk edge
`timescale 1ns/10ps
module cgr_pipe_model (
  input wire logic clk
);
  logic wr_enable = 1'b0;
  logic wr_to_accum = 1'b0;
  logic [2:0] wr_index = 3'h0;
  logic [31:0] wr_data = 32'h0000_0000;
  logic [4:0] flag_update_mask = 5'h00;
  logic [4:0] flag_update_value = 5'h00;
  logic src_ptr_update = 1'b0;
  logic [31:0] src_ptr_next_value = 32'h0000_0000;
  logic dst_ptr_update = 1'b0;
  logic [31:0] dst_ptr_next_value = 32'h0000_0000;
  logic loop_count_update = 1'b0;
  logic [11:0] loop_count_next_value = 12'h000;
  logic ctx_restore = 1'b0;
  logic [2:0] ctx_index = 3'h0;
  logic [31:0] ctx_data = 32'h0000_0000;
  logic exit_post = 1'b0;
  logic service_request = 1'b0;
  // ****
  // one-cycle operations; released data shows its inverse, except loop_count_next_value and flag_update_value, which hold
  // ****
  // callers keep reserved status bits zero except when probing storage
  task automatic wr(input logic [2:0] idx, input logic [31:0] d,
      input logic acc, input logic [4:0] m, input logic [4:0] v);
    @(posedge clk);
    wr_enable <= 1'b1;
    wr_to_accum <= acc;
    wr_index <= idx;
    wr_data <= d;
    flag_update_mask <= m;
    flag_update_value <= v;
    @(posedge clk);
    wr_enable <= 1'b0;
    wr_to_accum <= 1'b0;
    wr_data <= ~d;
    flag_update_mask <= 5'h00;
  endtask
  // restore colliding with an explicit write to the same register
  task automatic ctx(input logic [2:0] idx, input logic [31:0] d);
    @(posedge clk);
    ctx_restore <= 1'b1;
    ctx_index <= idx;
    ctx_data <= d;
    wr_enable <= 1'b1;
    wr_index <= idx;
    wr_data <= ~d;
    @(posedge clk);
    ctx_restore <= 1'b0;
    wr_enable <= 1'b0;
    ctx_data <= ~d;
  endtask
  task automatic upd(input logic [31:0] s, input logic [31:0] d,
      input logic [11:0] n);
    @(posedge clk);
    src_ptr_update <= 1'b1;
    src_ptr_next_value <= s;
    dst_ptr_update <= 1'b1;
    dst_ptr_next_value <= d;
    loop_count_update <= 1'b1;
    loop_count_next_value <= n;
    @(posedge clk);
    src_ptr_update <= 1'b0;
    dst_ptr_update <= 1'b0;
    loop_count_update <= 1'b0;
    src_ptr_next_value <= ~s;
    dst_ptr_next_value <= ~d;
  endtask
  // exit when is_exit, else a service request; fields set beforehand
  task automatic pulse(input logic is_exit);
    @(posedge clk);
    exit_post <= is_exit;
    service_request <= ~is_exit;
    @(posedge clk);
    exit_post <= 1'b0;
    service_request <= 1'b0;
  endtask
endmodule // cgr_pipe_model

// file: sim/cgr_regfile_test.sv
// self-checking bench for the general register file
// assumes cgr_pipe_model drives the write side; bench drives reads
`timescale 1ns/10ps
module cgr_regfile_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] rd_index = 3'h0;
  logic [5:0] parameter_ram_offset = 6'h00;
  logic [31:0] rd_a_data, rd_b_data, ctx_save_data, src_ptr, dst_ptr;
  logic [11:0] outer_loop_count;
  logic [13:0] parameter_ram_word_address;
  logic [1:0] service_type;
  logic [7:0] request_priority_number, current_priority_number;
  logic post_valid, channel_enable_bit, error_exit;
  int fails = 0;
  int check_count = 0;
  cgr_pipe_model pipe_u (.clk(clk));
  cgr_regfile dut_u (
    .clk(clk), .reset_n(reset_n),
    .rd_a_index(rd_index), .rd_a_data(rd_a_data),
    .rd_b_index(rd_index), .rd_b_data(rd_b_data),
    .wr_enable(pipe_u.wr_enable), .wr_to_accum(pipe_u.wr_to_accum),
    .wr_index(pipe_u.wr_index), .wr_data(pipe_u.wr_data),
    .flag_update_mask(pipe_u.flag_update_mask),
    .flag_update_value(pipe_u.flag_update_value),
    .src_ptr_update(pipe_u.src_ptr_update),
    .src_ptr_next_value(pipe_u.src_ptr_next_value),
    .dst_ptr_update(pipe_u.dst_ptr_update),
    .dst_ptr_next_value(pipe_u.dst_ptr_next_value),
    .loop_count_update(pipe_u.loop_count_update),
    .loop_count_next_value(pipe_u.loop_count_next_value),
    .src_ptr(src_ptr), .dst_ptr(dst_ptr),
    .outer_loop_count(outer_loop_count),
    .parameter_ram_offset(parameter_ram_offset), .parameter_ram_word_address(parameter_ram_word_address),
    .ctx_restore(pipe_u.ctx_restore), .ctx_index(pipe_u.ctx_index),
    .ctx_data(pipe_u.ctx_data), .ctx_save_index(rd_index),
    .ctx_save_data(ctx_save_data),
    .exit_post(pipe_u.exit_post), .post_valid(post_valid),
    .service_type(service_type),
    .request_priority_number(request_priority_number),
    .current_priority_number(current_priority_number),
    .service_request(pipe_u.service_request),
    .channel_enable_bit(channel_enable_bit), .error_exit(error_exit)
  );
  initial begin
    forever #50 clk = ~clk;
  end
  // ****
  // compare, read and closing tasks
  // ****
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [2:0] i, input logic [31:0] exp);
    @(posedge clk);
    rd_index <= i;
    #1;
    chk("read port a", exp, rd_a_data);
    chk("read port b", exp, rd_b_data);
    chk("save port", exp, ctx_save_data);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    $display("unexpected timeout expected done seen hang");
    end_of_test();
  end
  // ****
  // scenarios
  // ****
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], 32'h0000_0000);
    end
    for (int i = 0; i < 8; i++) begin
      pipe_u.wr(i[2:0], 32'hA5C3_3C50 + i, 1'b0, 5'h00, 5'h00);
    end
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], (i == 7) ? 32'h0000_3C57 : 32'hA5C3_3C50 + i);
    end
    pipe_u.wr(3'h3, 32'h1234_5678, 1'b1, 5'h00, 5'h00);
    rd(3'h0, 32'h1234_5678);
    rd(3'h3, 32'hA5C3_3C53);
    pipe_u.wr(3'h6, 32'h9C5A_F321, 1'b0, 5'h00, 5'h00);
    rd(3'h6, 32'h9C5A_F321);
    chk("loop count", 32'h0000_0321, {20'h0, outer_loop_count});
    pipe_u.upd(32'h8000_0004, 32'hFFFF_FFFC, 12'hFFF);
    #1;
    chk("source pointer", 32'h8000_0004, src_ptr);
    chk("destination pointer", 32'hFFFF_FFFC, dst_ptr);
    rd(3'h4, 32'h8000_0004);
    rd(3'h5, 32'hFFFF_FFFC);
    rd(3'h6, 32'h9C5A_FFFF);
    pipe_u.wr(3'h7, 32'h0000_FF07, 1'b0, 5'h03, 5'h00);
    rd(3'h7, 32'h0000_FF04);
    @(posedge clk);
    parameter_ram_offset <= 6'h2A;
    #1;
    chk("segment address", 32'h0000_3FEA, {18'h0, parameter_ram_word_address});
    for (int i = 0; i < 5; i++) begin
      pipe_u.wr(3'h7, 32'h0000_0000, 1'b0, 5'h01 << i, 5'h01 << i);
      rd(3'h7, 32'h0000_0001 << i);
    end
    pipe_u.wr(3'h7, 32'hFFFF_00A0, 1'b0, 5'h00, 5'h00);
    rd(3'h7, 32'h0000_00A0);
    chk("channel enable", 32'h0, {31'h0, channel_enable_bit});
    pipe_u.pulse(1'b0);
    #1;
    chk("error exit", 32'h1, {31'h0, error_exit});
    @(posedge clk);
    #1;
    chk("error exit", 32'h0, {31'h0, error_exit});
    pipe_u.wr(3'h7, 32'h0000_0040, 1'b0, 5'h00, 5'h00);
    #1;
    chk("channel enable", 32'h1, {31'h0, channel_enable_bit});
    pipe_u.pulse(1'b0);
    #1;
    chk("error exit", 32'h0, {31'h0, error_exit});
    pipe_u.wr(3'h7, 32'h0000_0000, 1'b0, 5'h00, 5'h00);
    pipe_u.pulse(1'b0);
    #1;
    chk("error exit", 32'h0, {31'h0, error_exit});
    pipe_u.pulse(1'b1);
    #1;
    chk("post valid", 32'h1, {31'h0, post_valid});
    chk("service type", 32'h1, {30'h0, service_type});
    chk("request priority", 32'h5A, {24'h0, request_priority_number});
    chk("current priority", 32'h9C, {24'h0, current_priority_number});
    @(posedge clk);
    #1;
    chk("post valid", 32'h0, {31'h0, post_valid});
    pipe_u.ctx(3'h2, 32'h0BAD_F00D);
    rd(3'h2, 32'h0BAD_F00D);
    pipe_u.ctx(3'h7, 32'hFFFF_1234);
    rd(3'h7, 32'h0000_1234);
    end_of_test();
  end
endmodule // cgr_regfile_test
